// ===== core/dpsc_pkg.sv
// Package: constants for the device power-state controller
package dpsc_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_WAKE = 8'h08;
    localparam logic [7:0] OFF_NVCFG = 8'h0C;
    // Control field positions
    localparam int CTRL_BLOCK_BIT = 2;
    localparam int CTRL_SWRST_BIT = 26;
    // Wake control field positions
    localparam int WAKE_EN_BIT = 0;
    localparam int WAKE_STAT_BIT = 1;
    localparam int WAKE_APM_BIT = 2;
    localparam int WAKE_PROXY_BIT = 3;
    // Nonvolatile image bits held in the config register
    localparam int NV_PHY_PD_BIT = 6;
    localparam int NV_DYN_OFF_BIT = 14;
    localparam int NV_COLD_ADV_BIT = 1;
    localparam int NV_GPIO_FLOAT_BIT = 2;
    localparam int NV_STATIC_OFF_BIT = 3;
    // Power state codes
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D3 = 2'h3;
    // Reset values
    localparam logic [31:0] NVCFG_RST = 32'h00000040;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DPSC_RESET_OFF = 2'h0,
        DPSC_UNINIT = 2'h1,
        DPSC_ACTIVE = 2'h2,
        DPSC_D3HOT = 2'h3
    } dpsc_state_t;
endpackage

// ===== core/dpsc_top.sv
// Device power-state controller with AXI4-Lite register slave
`timescale 1ns/1ps

module dpsc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins and power detection
    input wire logic power_good_n,
    input wire logic host_link_reset_n,
    input wire logic aux_supply_strap,
    input wire logic device_off_request_n,
    // Configuration space events
    input wire logic cfg_pm_write,
    input wire logic [1:0] cfg_pm_state,
    input wire logic cfg_cmd_write,
    input wire logic cfg_mem_enable,
    input wire logic cfg_io_enable,
    input wire logic cfg_bus_master_on,
    input wire logic cfg_flr,
    input wire logic link_l23_ready,
    input wire logic port_disable,
    // DMA engine and PHY status
    input wire logic dma_req_pending,
    input wire logic dma_busy,
    input wire logic cpl_outstanding,
    input wire logic phy_powered_down,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power state outputs
    output logic [1:0] power_state,
    output logic [1:0] power_mgmt_ctrl_status,
    output logic keep_config,
    output logic cmd_mem_enable,
    output logic cmd_io_enable,
    output logic link_l1_request,
    output logic master_req_allow,
    output logic bus_master_active_flag,
    output logic function_reset,
    output logic port_reset,
    output logic rx_drop,
    output logic disable_mode,
    output logic device_off,
    output logic gpio_float_in_off,
    output logic cold_wake_supported,
    output logic wake_event_enable,
    output logic wake_event_status
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pg_sync_ff, lr_sync_ff, aux_sync_ff, off_sync_ff;
    logic lr_prev_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pg_sync_ff <= 2'h0;
            lr_sync_ff <= 2'h0;
            aux_sync_ff <= 2'h0;
            off_sync_ff <= 2'h3;
            lr_prev_ff <= 1'b0;
        end else begin
            pg_sync_ff <= {pg_sync_ff[0], ~power_good_n};
            lr_sync_ff <= {lr_sync_ff[0], host_link_reset_n};
            aux_sync_ff <= {aux_sync_ff[0], aux_supply_strap};
            off_sync_ff <= {off_sync_ff[0], device_off_request_n};
            lr_prev_ff <= lr_sync_ff[1];
        end
    end

    logic pwr_up_rst, link_rst, link_rise;
    assign pwr_up_rst = pg_sync_ff[1];
    assign link_rst = ~lr_sync_ff[1];
    assign link_rise = lr_sync_ff[1] & ~lr_prev_ff;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic block_req_ff, swrst_pulse, wake_en_ff, wake_stat_ff, wake_apm_ff, proxy_offload_enable_ff, dma_seen_ff;
    logic [31:0] nvcfg_ff;
    dpsc_pkg::dpsc_state_t state_ff;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_held_ff, w_held_ff, do_write, wr_hit;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    assign do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
    assign wr_hit = (awaddr_ff == dpsc_pkg::OFF_CTRL) | (awaddr_ff == dpsc_pkg::OFF_WAKE)
        | (awaddr_ff == dpsc_pkg::OFF_NVCFG) | (awaddr_ff == dpsc_pkg::OFF_STATUS);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dpsc_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_ff & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_ff & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? dpsc_pkg::RESP_OKAY : dpsc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end
    logic wr_ctrl, wr_wake, wr_nv;
    assign wr_ctrl = do_write & (awaddr_ff == dpsc_pkg::OFF_CTRL);
    assign wr_wake = do_write & (awaddr_ff == dpsc_pkg::OFF_WAKE) & wstrb_ff[0];
    assign wr_nv = do_write & (awaddr_ff == dpsc_pkg::OFF_NVCFG);
    assign swrst_pulse = wr_ctrl & wstrb_ff[3] & wdata_ff[dpsc_pkg::CTRL_SWRST_BIT];
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[7:2], 2'h0})
            dpsc_pkg::OFF_CTRL: rd_word[dpsc_pkg::CTRL_BLOCK_BIT] = block_req_ff;
            dpsc_pkg::OFF_STATUS: rd_word = {26'h0, disable_mode, device_off, bus_master_active_flag,
                keep_config, state_ff};
            dpsc_pkg::OFF_WAKE: rd_word = {28'h0, proxy_offload_enable_ff, wake_apm_ff, wake_stat_ff, wake_en_ff};
            dpsc_pkg::OFF_NVCFG: rd_word = nvcfg_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= dpsc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? dpsc_pkg::RESP_OKAY : dpsc_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control and nonvolatile image
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || pwr_up_rst || link_rst || swrst_pulse) begin
            block_req_ff <= 1'b0;
        end else if (wr_ctrl && wstrb_ff[0]) begin
            block_req_ff <= wdata_ff[dpsc_pkg::CTRL_BLOCK_BIT];
        end
    end

    // Image loads at reset and writes to OFF_NVCFG update it; real part would fetch it from on-chip storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nvcfg_ff <= dpsc_pkg::NVCFG_RST;
        end else if (wr_nv) begin
            for (int i = 0; i < 4; i++) begin
                if (wstrb_ff[i]) begin
                    nvcfg_ff[i*8 +: 8] <= wdata_ff[i*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    logic go_d3, go_d0, go_active;
    assign go_d3 = cfg_pm_write & (cfg_pm_state == dpsc_pkg::PS_D3);
    assign go_d0 = cfg_pm_write & (cfg_pm_state == dpsc_pkg::PS_D0);
    assign go_active = cfg_cmd_write & (cfg_mem_enable | cfg_io_enable);
    always_ff @(posedge aclk) begin
        if (!aresetn || pwr_up_rst) begin
            state_ff <= dpsc_pkg::DPSC_RESET_OFF;
        end else begin
            unique case (state_ff)
                dpsc_pkg::DPSC_RESET_OFF: if (link_rise) state_ff <= dpsc_pkg::DPSC_UNINIT;
                dpsc_pkg::DPSC_UNINIT: begin
                    if (link_rst) state_ff <= dpsc_pkg::DPSC_RESET_OFF;
                    else if (go_d3) state_ff <= dpsc_pkg::DPSC_D3HOT;
                    else if (go_active) state_ff <= dpsc_pkg::DPSC_ACTIVE;
                end
                dpsc_pkg::DPSC_ACTIVE: begin
                    if (link_rst) state_ff <= dpsc_pkg::DPSC_RESET_OFF;
                    else if (go_d3) state_ff <= dpsc_pkg::DPSC_D3HOT;
                end
                dpsc_pkg::DPSC_D3HOT: begin
                    if (link_rst) state_ff <= dpsc_pkg::DPSC_RESET_OFF;
                    else if (go_d0) state_ff <= dpsc_pkg::DPSC_UNINIT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command bits, resets, link and master control
    // ------------------------------------------------------------
    logic in_d3, d3_entry, d3_exit;
    assign in_d3 = (state_ff == dpsc_pkg::DPSC_D3HOT);
    assign d3_entry = go_d3 & ~in_d3 & ~link_rst & (state_ff != dpsc_pkg::DPSC_RESET_OFF);
    assign d3_exit = in_d3 & go_d0 & ~link_rst;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_mem_enable <= 1'b0;
            dma_seen_ff <= 1'b0;
            cmd_io_enable <= 1'b0;
            keep_config <= 1'b1;
            function_reset <= 1'b0;
            port_reset <= 1'b0;
            rx_drop <= 1'b0;
            link_l1_request <= 1'b0;
            master_req_allow <= 1'b0;
            bus_master_active_flag <= 1'b0;
            power_state <= dpsc_pkg::DPSC_RESET_OFF;
            power_mgmt_ctrl_status <= dpsc_pkg::PS_D0;
        end else begin
            keep_config <= 1'b1;
            dma_seen_ff <= dma_busy; // Catches D3 or master-off mid-transfer
            power_state <= state_ff;
            power_mgmt_ctrl_status <= in_d3 ? dpsc_pkg::PS_D3 : dpsc_pkg::PS_D0;
            if (link_rst || (d3_entry && !keep_config)) begin
                cmd_mem_enable <= 1'b0;
                cmd_io_enable <= 1'b0;
            end else if (cfg_cmd_write) begin
                cmd_mem_enable <= cfg_mem_enable;
                cmd_io_enable <= cfg_io_enable;
            end
            // Full reset ignores keep-config mid-DMA stop too
            function_reset <= pwr_up_rst | cfg_flr | link_l23_ready | (in_d3 & link_rst)
                | ((~cfg_bus_master_on | port_disable | d3_entry) & dma_seen_ff);
            port_reset <= d3_exit;
            rx_drop <= d3_exit;
            link_l1_request <= in_d3;
            // No new requests while blocked or in D3
            master_req_allow <= ~block_req_ff & ~in_d3 & cfg_bus_master_on
                & (state_ff == dpsc_pkg::DPSC_ACTIVE);
            // Pending requests still drain; flag drops only once all idle
            bus_master_active_flag <= ~(block_req_ff & ~dma_req_pending & ~dma_busy & ~cpl_outstanding);
        end
    end

    // ------------------------------------------------------------
    // Wake control; enable and status survive reset-off only with cold wake support
    // ------------------------------------------------------------
    logic cold_sup, wake_clear;
    assign cold_sup = nvcfg_ff[dpsc_pkg::NV_COLD_ADV_BIT] & aux_sync_ff[1];
    // Without cold wake support, link reset clears too
    assign wake_clear = pwr_up_rst | (link_rst & ~cold_sup);
    always_ff @(posedge aclk) begin
        if (!aresetn || wake_clear) begin
            wake_en_ff <= 1'b0;
            wake_stat_ff <= 1'b0;
        end else if (wr_wake) begin
            wake_en_ff <= wdata_ff[dpsc_pkg::WAKE_EN_BIT];
            // Write one clears; nothing in this module ever sets it
            wake_stat_ff <= wake_stat_ff & ~wdata_ff[dpsc_pkg::WAKE_STAT_BIT];
        end
    end

    // Filter settings held across reset-off
    always_ff @(posedge aclk) begin
        if (!aresetn || pwr_up_rst) begin
            wake_apm_ff <= 1'b0;
            proxy_offload_enable_ff <= 1'b0;
        end else if (wr_wake) begin
            wake_apm_ff <= wdata_ff[dpsc_pkg::WAKE_APM_BIT];
            proxy_offload_enable_ff <= wdata_ff[dpsc_pkg::WAKE_PROXY_BIT];
        end
    end

    // ------------------------------------------------------------
    // Low-power modes
    // ------------------------------------------------------------
    logic no_wake, static_sel, dyn_sel;
    assign no_wake = ~wake_apm_ff & ~proxy_offload_enable_ff & ~wake_en_ff;
    assign dyn_sel = nvcfg_ff[dpsc_pkg::NV_DYN_OFF_BIT];
    // Dynamic wins if both set, keeping a single mode active
    assign static_sel = nvcfg_ff[dpsc_pkg::NV_STATIC_OFF_BIT] & ~dyn_sel;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disable_mode <= 1'b0;
            device_off <= 1'b0;
            gpio_float_in_off <= 1'b0;
            cold_wake_supported <= 1'b0;
            wake_event_enable <= 1'b0;
            wake_event_status <= 1'b0;
        end else begin
            disable_mode <= (state_ff == dpsc_pkg::DPSC_RESET_OFF) & no_wake
                & nvcfg_ff[dpsc_pkg::NV_PHY_PD_BIT];
            device_off <= (static_sel & ~off_sync_ff[1])
                | (dyn_sel & no_wake & phy_powered_down);
            gpio_float_in_off <= dyn_sel & no_wake & phy_powered_down
                & nvcfg_ff[dpsc_pkg::NV_GPIO_FLOAT_BIT];
            cold_wake_supported <= cold_sup;
            wake_event_enable <= wake_en_ff;
            wake_event_status <= wake_stat_ff;
        end
    end

endmodule // dpsc_top

// ===== test/dpsc_assertions.sv
// Checker: concurrent assertions on the power-state controller ports
`timescale 1ns/1ps
module dpsc_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins, config events and DMA status
    input wire logic power_good_n,
    input wire logic host_link_reset_n,
    input wire logic aux_supply_strap,
    input wire logic cfg_pm_write,
    input wire logic [1:0] cfg_pm_state,
    input wire logic cfg_cmd_write,
    input wire logic cfg_mem_enable,
    input wire logic cfg_io_enable,
    input wire logic cfg_flr,
    input wire logic dma_req_pending,
    input wire logic dma_busy,
    input wire logic cpl_outstanding,
    // Observed outputs
    input wire logic [1:0] power_state,
    input wire logic keep_config,
    input wire logic link_l1_request,
    input wire logic bus_master_active_flag,
    input wire logic function_reset,
    input wire logic disable_mode,
    input wire logic cold_wake_supported
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking dck @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Nets so that $past sees one signal
    wire logic wr_d3 = cfg_pm_write && cfg_pm_state == 2'h3;
    wire logic eng_idle = !dma_req_pending && !dma_busy && !cpl_outstanding;
    sequence s_d0_req;
        cfg_pm_write && cfg_pm_state == 2'h0;
    endsequence
    sequence s_cmd_en;
        cfg_cmd_write && (cfg_mem_enable || cfg_io_enable);
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_D3_BY_WRITE: assert property ((power_state == 2'h3 && $past(power_state) != 2'h3)
        |-> ($past(wr_d3) || $past(wr_d3, 2) || $past(wr_d3, 3))) else $error("D3 without request");
    AST_L1_IN_D3: assert property ((power_state == 2'h3) [*3] |-> link_l1_request)
        else $error("No L1 request in D3");
    AST_D3_EXIT: assert property (power_state == 2'h3 ##0 s_d0_req |-> ##[1:3] power_state == 2'h1)
        else $error("D3 exit missed");
    AST_LINK_RST_OFF: assert property ($fell(host_link_reset_n) |-> ##[1:6] power_state == 2'h0)
        else $error("Link reset ignored");
    AST_KEEP_ONE: assert property (keep_config) else $error("Keep-config low");
    AST_FLR_RESET: assert property (cfg_flr |-> ##[1:3] function_reset)
        else $error("No function reset on FLR");
    AST_FLAG_IDLE: assert property (!bus_master_active_flag |-> $past(eng_idle))
        else $error("Master flag clear while busy");
    AST_RISE_UNINIT: assert property ((power_state == 2'h0 && power_good_n && $rose(host_link_reset_n))
        |-> ##[1:6] power_state == 2'h1) else $error("No uninit after link reset");
    AST_UNINIT_ACT: assert property (power_state == 2'h1 ##0 s_cmd_en |-> ##[1:3] power_state == 2'h2)
        else $error("No active after enable");
    AST_DIS_IN_OFF: assert property (disable_mode |-> power_state == 2'h0 || $past(power_state) == 2'h0)
        else $error("Disable mode outside reset-off");
    AST_NO_COLD: assert property ((!aux_supply_strap) [*5] |-> !cold_wake_supported)
        else $error("Cold wake without aux");
endmodule // dpsc_assertions

bind dpsc_top dpsc_assertions i_chk (.*);

// ===== test/dpsc_dma_model.sv
// Partner model: DMA engines and root port completions
`timescale 1ns/1ps
module dpsc_dma_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Traffic control
    input wire logic go,
    input wire logic slow,
    input wire logic master_req_allow,
    // Engine status
    output logic dma_req_pending,
    output logic dma_busy,
    output logic cpl_outstanding
);
    // ----------------------------------------
    // Requests and completions
    // ----------------------------------------
    int cpl_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_req_pending <= 1'b0;
            dma_busy <= 1'b0;
            cpl_cnt <= 0;
        end else begin
            dma_req_pending <= go && master_req_allow;
            dma_busy <= go && master_req_allow;
            // Slow completions keep the flag up after blocking
            if (go && master_req_allow)
                cpl_cnt <= slow ? 12 : 2;
            else if (cpl_cnt != 0)
                cpl_cnt <= cpl_cnt - 1;
        end
    end
    assign cpl_outstanding = (cpl_cnt != 0);
endmodule // dpsc_dma_model

// ===== test/tb_top.sv
// Testbench: power-state controller against a behavioural host
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, power_good_n = 1'b0, host_link_reset_n = 1'b0, aux_supply_strap = 1'b0;
    logic device_off_request_n = 1'b1, cfg_pm_write = 1'b0, cfg_cmd_write = 1'b0, cfg_flr = 1'b0;
    logic [1:0] cfg_pm_state = 2'h0;
    logic cfg_mem_enable = 1'b0, cfg_io_enable = 1'b0, cfg_bus_master_on = 1'b1, link_l23_ready = 1'b0;
    logic port_disable = 1'b0, phy_powered_down = 1'b0, go = 1'b0, slow = 1'b1;
    logic dma_req_pending, dma_busy, cpl_outstanding;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, m_nv;
    logic [3:0] s_axi_wstrb = 4'hF;
    // Responses always accepted, so ready never toggles between transfers
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_state, power_mgmt_ctrl_status, rsp, idx;
    logic keep_config, cmd_mem_enable, cmd_io_enable, link_l1_request, master_req_allow, bus_master_active_flag;
    logic function_reset, port_reset, rx_drop, disable_mode, device_off, gpio_float_in_off;
    logic cold_wake_supported, wake_event_enable, wake_event_status;
    int err_total = 0, num_checks = 0, seed = 39964, n_frst = 0, n_prst = 0, n_drop = 0, k, n, st, fr0, pr0, dr0;

    always #4 aclk = ~aclk;
    // Pulses are counted so that short strobes are never missed
    always @(posedge aclk) begin
        n_frst += (function_reset === 1'b1);
        n_prst += (port_reset === 1'b1);
        n_drop += (rx_drop === 1'b1);
    end

    dpsc_top i_dut (.*);
    dpsc_dma_model i_host (.*);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic give_up();
        err_total++;
        give_verdict();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
                break;
        end
        rsp = s_axi_bresp;
        if (k == 50)
            give_up();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
                break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        if (k == 50)
            give_up();
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_rsp);
        axi_rd(a);
        cmp(rd, exp);
        cmp(rsp, exp_rsp);
    endtask
    task automatic wait_st(input logic [1:0] e);
        for (k = 0; k < 40 && power_state !== e; k++)
            @(posedge aclk);
        if (k == 40)
            give_up();
        cmp(power_state, e);
    endtask
    task automatic pm_wr(input logic [1:0] s);
        cfg_pm_state <= s;
        cfg_pm_write <= 1'b1;
        @(posedge aclk);
        cfg_pm_write <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic cmd_wr(input logic io);
        cfg_mem_enable <= 1'b1;
        cfg_io_enable <= io;
        cfg_cmd_write <= 1'b1;
        @(posedge aclk);
        cfg_cmd_write <= 1'b0;
        @(posedge aclk);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        m_nv = dpsc_pkg::NVCFG_RST;
        tick(4);
        aresetn <= 1'b1;
        power_good_n <= 1'b1;
        tick(4);
        cmp(keep_config, 32'h1);
        rd_cmp(dpsc_pkg::OFF_STATUS, {26'h0, m_nv[6], 1'b0, 1'b1, 1'b1, 2'h0}, dpsc_pkg::RESP_OKAY);
        rd_cmp(dpsc_pkg::OFF_NVCFG, m_nv, dpsc_pkg::RESP_OKAY);
        axi_wr(8'h10, $random(seed));
        cmp(rsp, dpsc_pkg::RESP_SLVERR);
        rd_cmp(8'h10, 32'h0, dpsc_pkg::RESP_SLVERR);
        cmp(power_state, 32'h0);
        $display("Test reset values done");
        host_link_reset_n <= 1'b1;
        wait_st(2'h1);
        cmd_wr(1'($random(seed)));
        wait_st(2'h2);
        $display("Test power-up path done");
        go <= 1'b1;
        tick(4);
        cmp(master_req_allow, 32'h1);
        axi_wr(dpsc_pkg::OFF_CTRL, 32'h1 << dpsc_pkg::CTRL_BLOCK_BIT);
        tick(3);
        cmp(master_req_allow, 32'h0);
        for (n = 0; n < 30; n++) begin
            axi_rd(dpsc_pkg::OFF_STATUS);
            if (rd[3] === 1'b0)
                break;
        end
        cmp(n < 30, 32'h1);
        cmp(cpl_outstanding, 32'h0);
        axi_wr(dpsc_pkg::OFF_CTRL, 32'h1 << dpsc_pkg::CTRL_SWRST_BIT);
        tick(3);
        cmp(master_req_allow, 32'h1);
        $display("Test master disable done");
        fr0 = n_frst;
        pm_wr(dpsc_pkg::PS_D3);
        wait_st(2'h3);
        tick(2);
        cmp(link_l1_request, 32'h1);
        cmp(power_mgmt_ctrl_status, 32'h3);
        cmp(cmd_mem_enable, 32'h1);
        cmp(n_frst > fr0, 32'h1);
        go <= 1'b0;
        pr0 = n_prst;
        dr0 = n_drop;
        pm_wr(dpsc_pkg::PS_D0);
        wait_st(2'h1);
        tick(2);
        cmp(n_prst > pr0, 32'h1);
        cmp(n_drop > dr0, 32'h1);
        cmp(link_l1_request, 32'h0);
        $display("Test D3 cycle done");
        cmd_wr(1'b0);
        wait_st(2'h2);
        axi_wr(dpsc_pkg::OFF_WAKE, 32'hD);
        tick(2);
        cmp(wake_event_enable, 32'h1);
        host_link_reset_n <= 1'b0;
        wait_st(2'h0);
        tick(2);
        rd_cmp(dpsc_pkg::OFF_WAKE, 32'hC, dpsc_pkg::RESP_OKAY);
        cmp(wake_event_enable, 32'h0);
        cmp(disable_mode, 32'h0);
        axi_wr(dpsc_pkg::OFF_WAKE, 32'h0);
        tick(3);
        cmp(disable_mode, m_nv[6]);
        fr0 = n_frst;
        cfg_flr <= 1'b1;
        tick(1);
        cfg_flr <= 1'b0;
        tick(3);
        cmp(n_frst > fr0, 32'h1);
        $display("Test reset-off done");
        st = $random(seed);
        for (n = 0; n < 4; n++) begin
            idx = 2'(n + st);
            m_nv = dpsc_pkg::NVCFG_RST | (32'(idx[0]) << dpsc_pkg::NV_COLD_ADV_BIT);
            aux_supply_strap <= idx[1];
            axi_wr(dpsc_pkg::OFF_NVCFG, m_nv);
            tick(5);
            cmp(cold_wake_supported, idx[0] & idx[1]);
        end
        $display("Test cold wake done");
        m_nv = dpsc_pkg::NVCFG_RST | (32'h1 << dpsc_pkg::NV_DYN_OFF_BIT) | (32'h1 << dpsc_pkg::NV_GPIO_FLOAT_BIT);
        phy_powered_down <= 1'b1;
        axi_wr(dpsc_pkg::OFF_NVCFG, m_nv);
        tick(5);
        cmp(device_off, 32'h1);
        cmp(gpio_float_in_off, 32'h1);
        axi_wr(dpsc_pkg::OFF_NVCFG, dpsc_pkg::NVCFG_RST | (32'h1 << dpsc_pkg::NV_STATIC_OFF_BIT));
        device_off_request_n <= 1'b0;
        tick(5);
        cmp(device_off, 32'h1);
        device_off_request_n <= 1'b1;
        tick(5);
        cmp(device_off, 32'h0);
        $display("Test device off done");
        give_verdict();
    end
endmodule // tb_top
